// ### dcs_pkg.sv
// Purpose: Shared constants and types of the command scheduler.
// Assumes: 32-bit register port, byte offsets, one word per register.
// Notes:   Priority value 0 is the highest request priority.
// Notes on behaviour
// R01 - Must-level refresh outranks every other command.
// R02 - Then read, write, activate, precharge, power-down, soft refresh, self-refresh.
// R03 - Among equal top priority, the oldest read or write wins.
// R04 - Oldest command past its age limit outranks everything but Must-level refresh.
// R05 - Hard or soft reset drops all activity and restarts startup.
// R06 - Config write with refresh-disable clear restarts init after transfers drain.
// R07 - Unsynced masters write, dummy write and read the ID register first.
// R08 - Each command maps to class 1 or 2 by priority or master ID.
// R09 - Three ID/mask pairs per class; mask ignores low ID bits.
// R10 - Without programming, every command falls into class 2.
// R11 - Command reaching its class limit goes next; highest priority first.
// R12 - An expired command that is also oldest goes first regardless.
// R13 - 13-bit interval counter reloads at zero, reset and rate write.
// R14 - Backlog counts reloads up to 15, issued refreshes down to 0.
// R15 - After a refresh, urgency waits out the refresh cycle time.
// R16 - Backlog above 0, 4, 7 gives May, Release and Must levels.
// R17 - Accesses resume when Release clears, or after one refresh if expired.
// R18 - Refresh counters halt in self-refresh and start after init.
// R19 - Low-power select 2 enters self-refresh after idle delay, clock enable low.
// R20 - Exit self-refresh on mode change, access request or zero delay.
// R21 - Accesses beat self-refresh; drain first, re-enter after servicing.
// R22 - Software checks self-refresh status and idle before resetting.
// R23 - Software never enables both double-rate self-refresh options.
// R24 - Status bit shows the memory is held in self-refresh.
package dcs_pkg;
   // Register byte offsets
   localparam logic [7:0] ID_OFS      = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] CONFIG_OFS  = 8'h08;
   localparam logic [7:0] REFCTL_OFS  = 8'h0c;
   localparam logic [7:0] TIM1_OFS    = 8'h10;
   localparam logic [7:0] PWR_OFS     = 8'h14;
   localparam logic [7:0] LAT_OFS     = 8'h18;
   localparam logic [7:0] PMAP_OFS    = 8'h1c;
   localparam logic [7:0] IDMAP_OFS   = 8'h20;
   // Field positions
   localparam int STAT_SR_BIT    = 0;
   localparam int STAT_INIT_BIT  = 1;
   localparam int STAT_BLOG_LSB  = 4;
   localparam int REF_DIS_BIT    = 31;
   localparam int PWR_LP_LSB     = 8;
   localparam int LAT_C1_LSB     = 8;
   localparam int LAT_C2_LSB     = 16;
   localparam int MAP_MASK_LSB   = 8;
   localparam int MAP_EN_BIT     = 16;
   // Reset values and the self-refresh low-power select code
   localparam logic [12:0] RATE_RST   = 13'h1860;
   localparam logic [7:0]  TRFC_RST   = 8'h40;
   localparam logic [7:0]  LIMIT_RST  = 8'hff;
   localparam logic [1:0]  LP_SELF    = 2'h2;
   // Refresh urgency thresholds and backlog ceiling
   localparam logic [3:0]  MAY_TH     = 4'h0;
   localparam logic [3:0]  REL_TH     = 4'h4;
   localparam logic [3:0]  MUST_TH    = 4'h7;
   localparam logic [3:0]  BLOG_MAX   = 4'hf;

   typedef enum logic [1:0] {
      ST_INIT_DRAIN, ST_INIT_RUN, ST_RUN, ST_SELF
   } dcs_state_e;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_READ, CMD_WRITE, CMD_ACT, CMD_PRE,
      CMD_PD, CMD_REF, CMD_SRE, CMD_SRX
   } dcs_cmd_e;
endpackage : dcs_pkg

// ### dcs_sched.sv
// Purpose: Command ranking, refresh and self-refresh control.
// Assumes: Queue slots presented as flat ports, same clock as clk.
// Notes:   One command per two cycles so a granted slot can retire.
//
// The register offsets and the plain strobed port are this design's own decisions.
module dcs_sched
   import dcs_pkg::*;
#(
   parameter int          NSLOT    = 16,
   parameter int          INIT_CYC = 64,
   parameter logic [31:0] ID_VALUE = 32'h0000_0a5a // Arbitrary value
)(
   // Clock and resets
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             softRstN,
   // Register port
   input  wire logic [7:0]       regAddr,
   input  wire logic [31:0]      regWdata,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic      [31:0]      regRdataQ,
   // Command queue view
   input  wire logic [NSLOT-1:0] slotValid,
   input  wire logic [NSLOT-1:0] slotWrite,
   input  wire logic [NSLOT-1:0] slotBankOpen,
   input  wire logic [NSLOT-1:0] slotBlocked,
   input  wire logic [2:0]       slotPrio  [NSLOT],
   input  wire logic [7:0]       slotMstId [NSLOT],
   // Bank and power requests
   input  wire logic             actReq,
   input  wire logic             preReq,
   input  wire logic             pdReq,
   input  wire logic             allBanksClosed,
   input  wire logic             xferBusy,
   // Memory side
   input  wire logic             memClkOut,
   output logic                  memClkEnPinQ,
   // Issued command
   output logic                  cmdValidQ,
   output dcs_cmd_e              cmdQ,
   output logic [$clog2(NSLOT)-1:0] cmdSlotQ,
   output logic                  selfRefQ,
   output logic                  initDoneQ
);
   localparam int IW = $clog2(NSLOT);

   // Parameter sanity
   if (NSLOT < 2 || INIT_CYC < 1)
   begin : badParam
      $error("dcs_sched: NSLOT must be >= 2 and INIT_CYC >= 1");
   end

   // Software registers
   logic [31:0] cfgQ;
   logic [12:0] rateQ;
   logic        refDisQ;
   logic [7:0]  tRfcQ;
   logic [1:0]  lpSelQ;
   logic [7:0]  srDelayQ;
   logic [7:0]  oldLimQ;
   logic [7:0]  c1LimQ;
   logic [7:0]  c2LimQ;
   logic [7:0]  prioMapQ;
   logic [7:0]  mapIdQ   [6];
   logic [2:0]  mapMaskQ [6];
   logic        mapEnQ   [6];

   // Scheduler state
   dcs_state_e  stateQ;
   logic [$clog2(INIT_CYC+1)-1:0] initCntQ;
   logic [12:0] refIntQ;
   logic [3:0]  backlogQ;
   logic [7:0]  refWaitQ;
   logic        refModeQ;
   logic [7:0]  srIdleQ;
   logic [7:0]  waitQ [NSLOT];
   logic        mcS1Q, mcS2Q, mcS3Q;

   // Combinational results
   dcs_cmd_e    sel;
   logic [IW-1:0] selSlot;
   logic        issueOk, issue, refIssue, reload;
   logic        mayLvl, relLvl, mustLvl;
   logic        cfgWrite, rateWrite;
   logic [NSLOT-1:0] cls1, expired, rdCand, wrCand;
   logic        anyExp, rdF, wrF, exF, oldF, srGo, srExit, idle, mcEdge;
   logic [IW-1:0] rdI, wrI, exI, oldI;
   logic [2:0]  rdP, wrP, exP;

   assign cfgWrite  = regWr && regAddr == CONFIG_OFS;
   assign rateWrite = regWr && regAddr == REFCTL_OFS;

   // Register writes; soft reset leaves them alone
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfgQ     <= 32'h0000_0000;
         rateQ    <= RATE_RST;
         refDisQ  <= 1'b0;
         tRfcQ    <= TRFC_RST;
         lpSelQ   <= 2'h0;
         srDelayQ <= 8'h00;
         oldLimQ  <= LIMIT_RST;
         c1LimQ   <= LIMIT_RST;
         c2LimQ   <= LIMIT_RST;
         prioMapQ <= 8'h00; // R10
         for (int k = 0; k < 6; k++)
         begin
            mapIdQ[k]   <= 8'h00;
            mapMaskQ[k] <= 3'h0;
            mapEnQ[k]   <= 1'b0;
         end
      end
      else if (regWr)
      begin
         // Writes to the ID word are accepted and dropped
         unique case (regAddr)
            CONFIG_OFS: cfgQ <= regWdata;
            REFCTL_OFS:
            begin
               rateQ   <= regWdata[12:0];
               refDisQ <= regWdata[REF_DIS_BIT];
            end
            TIM1_OFS: tRfcQ <= regWdata[7:0];
            PWR_OFS:
            begin
               srDelayQ <= regWdata[7:0];
               lpSelQ   <= regWdata[PWR_LP_LSB+:2];
            end
            LAT_OFS:
            begin
               oldLimQ <= regWdata[7:0];
               c1LimQ  <= regWdata[LAT_C1_LSB+:8];
               c2LimQ  <= regWdata[LAT_C2_LSB+:8];
            end
            PMAP_OFS: prioMapQ <= regWdata[7:0];
            default:
            begin
               for (int k = 0; k < 6; k++)
               begin
                  if (regAddr == IDMAP_OFS + 8'(4 * k))
                  begin
                     mapIdQ[k]   <= regWdata[7:0];
                     mapMaskQ[k] <= regWdata[MAP_MASK_LSB+:3];
                     mapEnQ[k]   <= regWdata[MAP_EN_BIT];
                  end
               end
            end
         endcase
      end
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         regRdataQ <= 32'h0000_0000;
      else if (!regRd)
         regRdataQ <= 32'h0000_0000;
      else
      begin
         regRdataQ <= 32'h0000_0000;
         unique case (regAddr)
            ID_OFS:     regRdataQ <= ID_VALUE; // R07
            STATUS_OFS:
               regRdataQ <= {24'h0, backlogQ, 2'h0, initDoneQ,
                             selfRefQ}; // R24
            CONFIG_OFS: regRdataQ <= cfgQ;
            REFCTL_OFS: regRdataQ <= {refDisQ, 18'h0, rateQ};
            TIM1_OFS:   regRdataQ <= {24'h0, tRfcQ};
            PWR_OFS:    regRdataQ <= {22'h0, lpSelQ, srDelayQ};
            LAT_OFS:    regRdataQ <= {8'h0, c2LimQ, c1LimQ, oldLimQ};
            PMAP_OFS:   regRdataQ <= {24'h0, prioMapQ};
            default:
            begin
               for (int k = 0; k < 6; k++)
               begin
                  if (regAddr == IDMAP_OFS + 8'(4 * k))
                     regRdataQ <= {15'h0, mapEnQ[k], 5'h0,
                                   mapMaskQ[k], mapIdQ[k]};
               end
            end
         endcase
      end
   end

   // Class of service: ID pairs first, then priority map
   always_comb
   begin
      for (int i = 0; i < NSLOT; i++)
      begin
         logic m1, m2;
         m1 = 1'b0;
         m2 = 1'b0;
         for (int k = 0; k < 3; k++)
         begin
            if (mapEnQ[k] && ((slotMstId[i] ^ mapIdQ[k])
                & 8'(8'hff << mapMaskQ[k])) == 8'h00)
               m1 = 1'b1; // R09
            if (mapEnQ[k+3] && ((slotMstId[i] ^ mapIdQ[k+3])
                & 8'(8'hff << mapMaskQ[k+3])) == 8'h00)
               m2 = 1'b1; // R09
         end
         cls1[i] = m1 || (!m2 && prioMapQ[slotPrio[i]]); // R08
         expired[i] = slotValid[i]
                    && waitQ[i] >= (cls1[i] ? c1LimQ : c2LimQ); // R11
         rdCand[i] = slotValid[i] && !slotWrite[i] && slotBankOpen[i]
                   && !slotBlocked[i];
         wrCand[i] = slotValid[i] && slotWrite[i] && slotBankOpen[i];
      end
      anyExp = |expired;
   end

   // Best by priority, ties to the oldest
   function automatic void pickBest(input  logic [NSLOT-1:0] m,
                                    output logic             f,
                                    output logic [IW-1:0]    idx,
                                    output logic [2:0]       p);
      f   = 1'b0;
      idx = '0;
      p   = 3'h7;
      for (int i = 0; i < NSLOT; i++)
      begin
         if (m[i] && (!f || slotPrio[i] < p
             || (slotPrio[i] == p && waitQ[i] > waitQ[idx]))) // R03
         begin
            f   = 1'b1;
            idx = IW'(i);
            p   = slotPrio[i];
         end
      end
   endfunction : pickBest

   // Candidate search
   always_comb
   begin
      pickBest(rdCand, rdF, rdI, rdP);
      pickBest(wrCand, wrF, wrI, wrP);
      pickBest(expired, exF, exI, exP); // R11
      oldF = 1'b0;
      oldI = '0;
      for (int i = 0; i < NSLOT; i++)
      begin
         if (slotValid[i] && (!oldF || waitQ[i] > waitQ[oldI]))
         begin
            oldF = 1'b1;
            oldI = IW'(i);
         end
      end
   end

   // Urgency levels from backlog
   assign mayLvl  = backlogQ > MAY_TH;  // R16
   assign relLvl  = backlogQ > REL_TH;  // R16
   assign mustLvl = backlogQ > MUST_TH; // R16

   // Self-refresh entry and exit terms
   assign idle   = !(|slotValid) && !actReq && !preReq && !pdReq
                && backlogQ == 4'h0 && !cmdValidQ; // R21
   assign srGo   = lpSelQ == LP_SELF && srDelayQ != 8'h00
                && srIdleQ >= srDelayQ; // R19
   assign srExit = lpSelQ != LP_SELF || |slotValid || actReq || preReq
                || srDelayQ == 8'h00; // R20

   // Command selection; gap cycle lets a granted slot retire
   assign issueOk = !cmdValidQ && softRstN;
   always_comb
   begin
      sel     = CMD_NONE;
      selSlot = '0;
      if (!issueOk)
         sel = CMD_NONE;
      else if (stateQ == ST_INIT_RUN)
      begin
         if (initCntQ == '0)
            sel = CMD_REF;
      end
      else if (stateQ == ST_SELF)
      begin
         if (srExit)
            sel = CMD_SRX; // R20
      end
      else if (stateQ == ST_RUN)
      begin
         // Must level blocks all else, even during the refresh wait
         if (mustLvl || refModeQ)
         begin
            if (refWaitQ == 8'h00 && backlogQ != 4'h0)
               sel = CMD_REF; // R01 R17
         end
         else if (oldF && (waitQ[oldI] >= oldLimQ || expired[oldI]))
         begin
            sel     = slotWrite[oldI] ? CMD_WRITE : CMD_READ; // R04 R12
            selSlot = oldI;
         end
         else if (exF)
         begin
            sel     = slotWrite[exI] ? CMD_WRITE : CMD_READ; // R11
            selSlot = exI;
         end
         else if (rdF && (!wrF || rdP <= wrP))
         begin
            sel     = CMD_READ; // R02
            selSlot = rdI;
         end
         else if (wrF)
         begin
            sel     = CMD_WRITE; // R02
            selSlot = wrI;
         end
         else if (actReq)
            sel = CMD_ACT; // R02
         else if (preReq)
            sel = CMD_PRE; // R02
         else if (pdReq)
            sel = CMD_PD; // R02
         else if (refWaitQ == 8'h00
                  && (relLvl || (mayLvl && allBanksClosed)))
            sel = CMD_REF; // R02 R16
         else if (srGo && !cfgWrite)
            sel = CMD_SRE; // R02 R21
      end
   end
   assign issue    = sel != CMD_NONE;
   assign refIssue = sel == CMD_REF;

   // Issued command register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmdValidQ <= 1'b0;
         cmdQ      <= CMD_NONE;
         cmdSlotQ  <= '0;
      end
      else
      begin
         cmdValidQ <= issue;
         cmdQ      <= sel;
         cmdSlotQ  <= selSlot;
      end
   end

   // Main state; reset release restarts startup
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stateQ    <= ST_INIT_RUN;
         initCntQ  <= ($clog2(INIT_CYC+1))'(INIT_CYC);
         initDoneQ <= 1'b0;
      end
      else if (!softRstN)
      begin
         stateQ    <= ST_INIT_RUN; // R05
         initCntQ  <= ($clog2(INIT_CYC+1))'(INIT_CYC);
         initDoneQ <= 1'b0;
      end
      else
      begin
         unique case (stateQ)
            ST_INIT_DRAIN:
            begin
               if (!xferBusy && !cmdValidQ)
                  stateQ <= ST_INIT_RUN; // R06
            end
            ST_INIT_RUN:
            begin
               if (initCntQ != '0)
                  initCntQ <= initCntQ - 1'b1;
               else if (refIssue)
               begin
                  stateQ    <= ST_RUN;
                  initDoneQ <= 1'b1;
               end
            end
            ST_RUN:
            begin
               if (cfgWrite && !refDisQ)
               begin
                  stateQ   <= ST_INIT_DRAIN; // R06
                  initCntQ <= ($clog2(INIT_CYC+1))'(INIT_CYC);
               end
               else if (sel == CMD_SRE)
                  stateQ <= ST_SELF; // R19
            end
            ST_SELF:
            begin
               if (sel == CMD_SRX)
                  stateQ <= ST_RUN; // R20
            end
         endcase
      end
   end

   // Clock enable pin and self-refresh status
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         memClkEnPinQ <= 1'b1;
         selfRefQ     <= 1'b0;
      end
      else if (!softRstN)
      begin
         memClkEnPinQ <= 1'b1;
         selfRefQ     <= 1'b0;
      end
      else if (sel == CMD_SRE)
      begin
         memClkEnPinQ <= 1'b0; // R19
         selfRefQ     <= 1'b1; // R24
      end
      else if (sel == CMD_SRX)
      begin
         memClkEnPinQ <= 1'b1;
         selfRefQ     <= 1'b0; // R24
      end
   end

   // Interval counter; halted until init completes after any reset and in self-refresh
   assign reload = initDoneQ && stateQ != ST_SELF && refIntQ == 13'h0;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         refIntQ <= RATE_RST; // R13
      else if (!softRstN || rateWrite)
         refIntQ <= rateWrite ? regWdata[12:0] : rateQ; // R13
      else if (initDoneQ && stateQ != ST_SELF) // R18
         refIntQ <= reload ? rateQ : refIntQ - 13'h1; // R13
   end

   // Backlog of outstanding refreshes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         backlogQ <= 4'h0;
      else if (!softRstN)
         backlogQ <= 4'h0;
      else if (reload && !(refIssue && backlogQ != 4'h0))
         backlogQ <= backlogQ == BLOG_MAX ? backlogQ
                     : backlogQ + 4'h1; // R14
      else if (refIssue && backlogQ != 4'h0
               && (!reload || backlogQ == BLOG_MAX))
         backlogQ <= backlogQ - 4'h1; // R14
   end

   // Refresh cycle wait and refresh state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         refWaitQ <= 8'h00;
         refModeQ <= 1'b0;
      end
      else if (!softRstN)
      begin
         refWaitQ <= 8'h00;
         refModeQ <= 1'b0;
      end
      else
      begin
         if (refIssue)
            refWaitQ <= tRfcQ; // R15
         else if (refWaitQ != 8'h00)
            refWaitQ <= refWaitQ - 8'h01;
         // Expired work forces exit after a single refresh
         if (refModeQ && (!relLvl || (refIssue && anyExp)))
            refModeQ <= 1'b0; // R17
         else if (mustLvl && stateQ == ST_RUN)
            refModeQ <= 1'b1;
      end
   end

   // Per-slot age counters, cleared while slot empty
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NSLOT; i++)
            waitQ[i] <= 8'h00;
      end
      else
      begin
         for (int i = 0; i < NSLOT; i++)
         begin
            if (!slotValid[i] || !softRstN)
               waitQ[i] <= 8'h00;
            else if (waitQ[i] != 8'hff)
               waitQ[i] <= waitQ[i] + 8'h01;
         end
      end
   end

   // Memory clock pin sampled; edge taken from the second and third stages
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mcS1Q <= 1'b0;
         mcS2Q <= 1'b0;
         mcS3Q <= 1'b0;
      end
      else
      begin
         mcS1Q <= memClkOut;
         mcS2Q <= mcS1Q;
         mcS3Q <= mcS2Q;
      end
   end
   assign mcEdge = mcS2Q && !mcS3Q;

   // Idle time in memory clock cycles
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         srIdleQ <= 8'h00;
      else if (!idle || stateQ != ST_RUN || !softRstN)
         srIdleQ <= 8'h00;
      else if (mcEdge && srIdleQ != 8'hff)
         srIdleQ <= srIdleQ + 8'h01; // R19
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   mustRefWins_a: assert property (issue && mustLvl && stateQ == ST_RUN
      |=> cmdValidQ && cmdQ == CMD_REF) // R01
      else $error("must refresh not issued first");
   rateReload_a: assert property (reload && softRstN && !rateWrite
      |=> refIntQ == $past(rateQ)) // R13
      else $error("interval counter did not reload");
   blogSat_a: assert property (backlogQ == BLOG_MAX && !refIssue
      && softRstN |=> backlogQ == BLOG_MAX) // R14
      else $error("backlog wrapped");
   rfcGap_a: assert property (cmdValidQ && cmdQ == CMD_REF
      && $past(tRfcQ) > 8'h02 |-> ##1 !(cmdValidQ && cmdQ == CMD_REF)
      [*2]) // R15
      else $error("refresh reissued inside refresh cycle");
   ckeSelf_a: assert property (selfRefQ |-> !memClkEnPinQ) // R19
      else $error("clock enable high in self-refresh");
   srStatus_a: assert property (softRstN && $past(softRstN)
      |-> selfRefQ == (stateQ == ST_SELF)) // R24
      else $error("self-refresh status mismatch");
   softRst_a: assert property (!softRstN
      |=> !cmdValidQ && !initDoneQ && stateQ == ST_INIT_RUN) // R05
      else $error("soft reset did not restart");
   cfgInit_a: assert property (cfgWrite && !refDisQ && stateQ == ST_RUN
      && softRstN |=> stateQ == ST_INIT_DRAIN) // R06
      else $error("config write did not start init");
   srHold_a: assert property (stateQ == ST_SELF && $past(stateQ)
      == ST_SELF && softRstN && !$past(rateWrite)
      |-> $stable(refIntQ)) // R18
      else $error("refresh counter ran in self-refresh");
   exitSelf_a: assert property (stateQ == ST_SELF && issueOk && srExit
      |=> cmdValidQ && cmdQ == CMD_SRX) // R20
      else $error("self-refresh not left");

   refCov_c:  cover property (cmdValidQ && cmdQ == CMD_REF && initDoneQ);
   selfCov_c: cover property (selfRefQ ##1 !selfRefQ);
   expCov_c:  cover property (issue && exF && sel != CMD_REF);
   modeCov_c: cover property (refModeQ ##1 !refModeQ);
endmodule : dcs_sched

// ### dcs_mem_model.sv
// Purpose: Memory-side model supplying the memory clock pin.
// Assumes: Memory clock of 32 ns, phase unrelated to the core clock.
// Notes:   Free running, as a real memory clock output would be.
module dcs_mem_model (
   // Memory pins
   output logic      memClk,
   input  wire logic clkEn
);
   timeunit 1ns;
   timeprecision 1ps;
   int lowEdges;
   // Odd start offset keeps edges apart from the core clock
   initial
   begin
      memClk = 1'b0;
      #3;
      forever #16 memClk = ~memClk;
   end
   // Memory clocks spent with clock enable low, for waveform review
   initial lowEdges = 0;
   always @(posedge memClk)
      lowEdges <= clkEn ? 0 : lowEdges + 1;
endmodule : dcs_mem_model

// ### tb_top.sv
// Purpose: Self-checking bench of the command scheduler.
// Assumes: Four queue slots and a short init count.
// Notes:   Random pairs come from a fixed xorshift seed.
module tb_top
   import dcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] IDV = 32'h0000_1234; // Arbitrary value
   logic        clk, rst_n, softRstN, regWr, regRd, actReq, preReq, pdReq;
   logic        allBanksClosed, xferBusy, memClkOut, memClkEnPinQ;
   logic        cmdValidQ, selfRefQ, initDoneQ, r;
   logic [7:0]  regAddr;
   logic [31:0] regWdata, regRdataQ, seed;
   logic [3:0]  slotValid, slotWrite;
   logic [2:0]  slotPrio  [4];
   logic [7:0]  slotMstId [4];
   logic [1:0]  cmdSlotQ, gs;
   dcs_cmd_e    cmdQ, gk;
   int          bad_count, cmp_count;
   dcs_sched #(.NSLOT(4), .INIT_CYC(4), .ID_VALUE(IDV)) i_dut (
      .clk(clk), .rst_n(rst_n), .softRstN(softRstN), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdataQ(regRdataQ), .slotValid(slotValid), .slotWrite(slotWrite),
      .slotBankOpen(4'hf), .slotBlocked(4'h0), .slotPrio(slotPrio),
      .slotMstId(slotMstId), .actReq(actReq), .preReq(preReq),
      .pdReq(pdReq), .allBanksClosed(allBanksClosed), .xferBusy(xferBusy),
      .memClkOut(memClkOut), .memClkEnPinQ(memClkEnPinQ),
      .cmdValidQ(cmdValidQ), .cmdQ(cmdQ), .cmdSlotQ(cmdSlotQ),
      .selfRefQ(selfRefQ), .initDoneQ(initDoneQ));
   dcs_mem_model i_mem (.memClk(memClkOut), .clkEn(memClkEnPinQ));
   // Core clock, 4 ns
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction : xs
   // Read wins unless the write has strictly better priority
   function automatic logic rd_first(logic [2:0] pr, logic [2:0] pw);
      return pr <= pw;
   endfunction : rd_first
   task automatic chk(string n, logic [31:0] g, logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task automatic rd(logic [7:0] a, logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
      chk("regRdataQ", regRdataQ, e);
   endtask : rd
   // Bounded wait for the one-cycle command pulse
   task automatic waitc();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (cmdValidQ !== 1'b1 && n < 500);
      gk = cmdQ;
      gs = cmdSlotQ;
   endtask : waitc
   task automatic getc(dcs_cmd_e e, logic [1:0] es);
      waitc();
      chk("cmdQ", gk, e);
      chk("cmdSlotQ", gs, es);
   endtask : getc
   // Low-priority slot 0 against a stream on slots 1 and 2
   task automatic starve(logic [31:0] lat, logic [31:0] map, logic e);
      int   at;
      logic hit;
      hit = 1'b0;
      at = 0;
      wr(LAT_OFS, lat);
      wr(PMAP_OFS, map);
      slotPrio[0] <= 3'h7;
      slotPrio[1] <= 3'h0;
      slotValid <= 4'b0111;
      while (!hit && at < 40)
      begin
         waitc();
         slotValid[gs] <= 1'b0;
         hit = (gs === 2'h0);
         at++;
         @(posedge clk);
         slotValid[gs] <= !hit;
      end
      chk("starved", hit && at > 3, e);
      @(posedge clk);
      slotValid <= 4'b0000;
   endtask : starve
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   // Hang guard, well past the expected run length
   initial
   begin
      repeat (30000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   initial
   begin
      {rst_n, regWr, regRd, actReq, preReq, pdReq, xferBusy} = '0;
      {softRstN, allBanksClosed} = 2'b11;
      {regAddr, regWdata, slotValid, slotWrite} = '0;
      seed = 32'h0000_aff0;
      foreach (slotPrio[i])
      begin
         slotPrio[i] = 3'h0;
         slotMstId[i] = 8'h00;
      end
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      getc(CMD_REF, 2'h0);
      chk("initDoneQ", initDoneQ, 1'b1);
      wr(ID_OFS, 32'h0);
      rd(ID_OFS, IDV);
      rd(8'hfc, 32'h0);
      $display("register test done");
      for (int i = 0; i < 24; i++)
      begin
         @(posedge clk);
         seed = xs(seed);
         slotPrio[0] <= seed[2:0];
         slotPrio[1] <= seed[5:3];
         slotMstId[0] <= seed[15:8];
         slotWrite <= 4'b0010;
         slotValid <= 4'b0011;
         r = rd_first(seed[2:0], seed[5:3]);
         getc(r ? CMD_READ : CMD_WRITE, r ? 2'h0 : 2'h1);
         slotValid <= r ? 4'b0010 : 4'b0001;
         getc(r ? CMD_WRITE : CMD_READ, r ? 2'h1 : 2'h0);
         slotValid <= 4'b0000;
      end
      {actReq, preReq, pdReq} <= 3'b111;
      getc(CMD_ACT, 2'h0);
      actReq <= 1'b0;
      getc(CMD_PRE, 2'h0);
      preReq <= 1'b0;
      getc(CMD_PD, 2'h0);
      pdReq <= 1'b0;
      slotWrite <= 4'b0000;
      $display("ordering test done");
      starve(32'h00ff_ff10, 32'h0, 1'b1);
      starve(32'h00ff_10ff, 32'h80, 1'b1);
      starve(32'h00ff_10ff, 32'h0, 1'b0);
      starve(32'h0010_ffff, 32'h0, 1'b1);
      wr(LAT_OFS, 32'h00ff_ffff);
      $display("starvation test done");
      wr(PWR_OFS, 32'h0000_0204);
      getc(CMD_SRE, 2'h0);
      chk("memClkEnPinQ", memClkEnPinQ, 1'b0);
      slotValid <= 4'b0001;
      getc(CMD_SRX, 2'h0);
      getc(CMD_READ, 2'h0);
      slotValid <= 4'b0000;
      getc(CMD_SRE, 2'h0);
      rd(STATUS_OFS, 32'h3);
      softRstN <= 1'b0;
      repeat (4) @(posedge clk);
      chk("initDoneQ", initDoneQ, 1'b0);
      softRstN <= 1'b1;
      getc(CMD_REF, 2'h0);
      getc(CMD_SRE, 2'h0);
      wr(PWR_OFS, 32'h0);
      getc(CMD_SRX, 2'h0);
      chk("memClkEnPinQ", memClkEnPinQ, 1'b1);
      $display("self-refresh test done");
      xferBusy <= 1'b1;
      wr(CONFIG_OFS, 32'h0);
      repeat (20) @(posedge clk);
      xferBusy <= 1'b0;
      getc(CMD_REF, 2'h0);
      wr(REFCTL_OFS, 32'h0000_0040);
      getc(CMD_REF, 2'h0);
      rd(STATUS_OFS, 32'h2);
      $display("refresh test done");
      report_and_stop();
   end
endmodule : tb_top
